// [core/nlp_pkg.sv]
// Constants, register map and types of the link integrity poller.
`default_nettype none
package nlp_pkg;
  // ----------------------------------------------------------------
  // Clock and one-second tick
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FPC  = 8'h04;
  localparam logic [7:0] REG_WIN  = 8'h08;
  localparam logic [7:0] REG_TMR  = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_SEQ  = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN   = 0;
  localparam int CTRL_FAST = 1;
  localparam int CTRL_FWDA = 2;
  localparam int WIN_MWC   = 8;
  localparam int TMR_PVT   = 8;

  // ----------------------------------------------------------------
  // Reset values and legal ranges
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] FPC_DEF  = 8'h06;
  localparam logic [7:0] FPC_MIN  = 8'h01;
  localparam logic [3:0] ETH_DEF  = 4'h3;
  localparam logic [3:0] MWC_DEF  = 4'h4;
  localparam logic [3:0] NWIN_MIN = 4'h1;
  localparam logic [3:0] NWIN_MAX = 4'hA;
  localparam logic [4:0] PIT_DEF  = 5'h0A;
  localparam logic [4:0] PVT_DEF  = 5'h0F;
  localparam logic [4:0] TSEC_MIN = 5'h05;
  localparam logic [4:0] TSEC_MAX = 5'h1E;
  localparam int unsigned HIST_W  = 10;

  // ----------------------------------------------------------------
  // User side polling states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    US_OFF  = 2'b00,
    US_WAIT = 2'b01,
    US_IDLE = 2'b11
  } nlp_us_state_t;
endpackage
`default_nettype wire

// [core/nlp_poller.sv]
// Bidirectional link integrity poller for one network-to-network link.
// Operation
// [RL1] Run poller (user side) and responder (network side) at once.
// [RL2] Keep separate sequence numbers and parameters for each side; both sides share one error threshold and monitor window count.
// [RL3] Full report poll count 1..255, default 6.
// [RL4] Go inactive when error threshold errors fall in monitor window.
// [RL5] Poll interval timer 5..30 seconds, default 10.
// [RL6] Poll verify timer 5..30 seconds, default 15.
// [RL7] Error threshold should not exceed monitor window count.
// [RL8] Poll verify timer should exceed poll interval timer.
// [RL9] Send a status enquiry each time the poll interval expires.
// [RL10] Ask for a full report once every full report poll count polls.
// [RL11] Both ends share timers and error settings; poll count may differ.
// [RL12] Forward PVC status from full reports, async optionally, to user side.
// [RL13] Active bit sent is independent of the active bit received.
// [RL14] After a PVC change answer enquiries with a full report.
// [RL15] Sent status covers destination and every traversed network.
// [RL16] Start non-operational; need window count good polls, or fast mode.
// [RL17] Active PVC is encoded as 1, inactive as 0.
// [RL18] Missing enquiry or bad sequence numbers count as an error.
// [RL19] Timers run from a one-second tick; reset clears all counters.
`default_nettype none
module nlp_poller
  import nlp_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned PVC_W    = 10
) (
  input  wire logic             core_clk,        // System clock.
  input  wire logic             srst,            // Sync reset, high.
  input  wire logic [7:0]       reg_addr,        // Register address.
  input  wire logic [31:0]      reg_wdata,       // Register write data.
  input  wire logic             reg_we,          // Write strobe.
  input  wire logic             reg_re,          // Read strobe.
  output logic      [31:0]      reg_rdata,       // Read data, next cycle.
  input  wire logic             rx_rep_valid,    // Reply to our enquiry.
  input  wire logic             rx_rep_seq_ok,   // Its sequence numbers ok.
  input  wire logic             rx_enq_valid,    // Enquiry from peer.
  input  wire logic             rx_enq_seq_ok,   // Its sequence numbers ok.
  input  wire logic             rx_enq_full_req, // Peer asks full report.
  input  wire logic             rx_pvc_valid,    // Received PVC element.
  input  wire logic             rx_pvc_full,     // Element from full report.
  input  wire logic [PVC_W-1:0] rx_pvc_idx,      // Its PVC number.
  input  wire logic             rx_pvc_active,   // Its active bit.
  input  wire logic             pvc_change,      // Local PVC changed, pulse.
  input  wire logic             pvc_dest_ok,     // Destination is up.
  input  wire logic             pvc_path_ok,     // Far networks are up.
  output logic                  tx_enq,          // Send enquiry, pulse.
  output logic                  tx_enq_full,     // Enquiry asks full.
  output logic      [7:0]       tx_enq_seq,      // Enquiry send sequence.
  output logic                  tx_rep,          // Send reply, pulse.
  output logic                  tx_rep_full,     // Reply is a full report.
  output logic      [7:0]       tx_rep_seq,      // Reply send sequence.
  output logic                  tx_pvc_active,   // Active bit to send.
  output logic                  uni_pvc_valid,   // Forward PVC, pulse.
  output logic      [PVC_W-1:0] uni_pvc_idx,     // Forwarded PVC number.
  output logic                  uni_pvc_active,  // Forwarded active bit.
  output logic                  link_up          // Both sides operational.
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] err_count(logic [HIST_W-1:0] h,
                                           logic [3:0] w);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < HIST_W; i++) begin
      if (i < int'(w)) c = 4'(c + 4'(h[i]));
    end
    return c;
  endfunction

  function automatic logic op_next(logic op, logic first, logic fast,
                                   logic [HIST_W-1:0] h, logic [3:0] cons,
                                   logic [3:0] eth, logic [3:0] mwc);
    if (err_count(h, mwc) >= eth) return 1'b0;   // [RL4]
    if (cons >= mwc) return 1'b1;                // [RL16]
    if (fast && first && !h[0]) return 1'b1;     // [RL16]
    return op;
  endfunction

  function automatic logic [7:0] seq_inc(logic [7:0] s);
    return (s == 8'hFF) ? 8'h01 : 8'(s + 8'h01);
  endfunction

  function automatic logic [3:0] cons_inc(logic [3:0] c, logic err);
    if (err) return 4'h0;
    return (c == NWIN_MAX) ? c : 4'(c + 4'h1);
  endfunction

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  nlp_tick_if tk ();
  logic [2:0] ctrl_q, ctrl_d;
  logic       en;
  assign en = ctrl_q[CTRL_EN];

  nlp_tick_gen #(.CYCLES(TICK_LEN)) u_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (en),
    .tk       (tk)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0]  fpc_q, fpc_d;
  logic [3:0]  eth_q, eth_d, mwc_q, mwc_d;
  logic [4:0]  pit_q, pit_d, pvt_q, pvt_d;
  logic [31:0] rdata_q, rdata_d;
  logic        chg_q, chg_d;
  logic [3:0]  weth, wmwc;
  logic [4:0]  wpit, wpvt;

  // ----------------------------------------------------------------
  // Side state
  // ----------------------------------------------------------------
  nlp_us_state_t     us_st_q, us_st_d;
  logic [4:0]        us_tmr_q, us_tmr_d, nw_tmr_q, nw_tmr_d;
  logic [7:0]        us_poll_q, us_poll_d, us_seq_q, us_seq_d;
  logic [7:0]        nw_seq_q, nw_seq_d;
  logic [HIST_W-1:0] us_hist_q, us_hist_d, nw_hist_q, nw_hist_d;
  logic [3:0]        us_cons_q, us_cons_d, nw_cons_q, nw_cons_d;
  logic              us_op_q, us_op_d, nw_op_q, nw_op_d;
  logic              us_first_q, us_first_d, nw_first_q, nw_first_d;
  logic              enq_q, enq_d, enqf_q, enqf_d, rep_q, rep_d;
  logic              repf_q, repf_d, act_q, act_d;
  logic              fwd_q, fwd_d, fact_q, fact_d, up_q, up_d;
  logic [PVC_W-1:0]  fidx_q, fidx_d;
  logic              us_exp, nw_exp, us_ev, us_err, nw_ev, nw_err;

  assign weth = reg_wdata[3:0];
  assign wmwc = reg_wdata[WIN_MWC+3:WIN_MWC];
  assign wpit = reg_wdata[4:0];
  assign wpvt = reg_wdata[TMR_PVT+4:TMR_PVT];
  assign us_exp = tk.sec_tick && (5'(us_tmr_q + 5'h01) >= pit_q);
  assign nw_exp = tk.sec_tick && (5'(nw_tmr_q + 5'h01) >= pvt_q);

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d  = ctrl_q;
    fpc_d   = fpc_q;
    eth_d   = eth_q;
    mwc_d   = mwc_q;
    pit_d   = pit_q;
    pvt_d   = pvt_q;
    rdata_d = 32'h0000_0000;
    if (reg_we) begin
      unique case (reg_addr)
        REG_CTRL: ctrl_d = reg_wdata[2:0];
        REG_FPC:  if (reg_wdata[7:0] >= FPC_MIN) fpc_d = reg_wdata[7:0];
        REG_WIN: begin // [RL4] [RL11]
          if (weth >= NWIN_MIN && weth <= NWIN_MAX) eth_d = weth;
          if (wmwc >= NWIN_MIN && wmwc <= NWIN_MAX) mwc_d = wmwc;
        end
        REG_TMR: begin // [RL5] [RL6]
          if (wpit >= TSEC_MIN && wpit <= TSEC_MAX) pit_d = wpit;
          if (wpvt >= TSEC_MIN && wpvt <= TSEC_MAX) pvt_d = wpvt;
        end
        default: ;
      endcase
    end
    if (reg_re) begin
      unique case (reg_addr)
        REG_CTRL: rdata_d = {29'h0, ctrl_q};
        REG_FPC:  rdata_d = {24'h0, fpc_q};
        REG_WIN:  rdata_d = {20'h0, mwc_q, 4'h0, eth_q};
        REG_TMR:  rdata_d = {19'h0, pvt_q, 3'h0, pit_q};
        REG_STAT: rdata_d = {16'h0, err_count(nw_hist_q, mwc_q),
                             err_count(us_hist_q, mwc_q), 1'b0,
                             (pvt_q <= pit_q),     // [RL8]
                             (eth_q > mwc_q),      // [RL7]
                             chg_q, 1'b0, up_q, nw_op_q, us_op_q};
        REG_SEQ:  rdata_d = {16'h0, nw_seq_q, us_seq_q};
        default:  rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // User side: enquiry origination and reply checking
  // ----------------------------------------------------------------
  always_comb begin
    us_st_d    = us_st_q;
    us_tmr_d   = us_tmr_q;
    us_poll_d  = us_poll_q;
    us_seq_d   = us_seq_q;
    us_hist_d  = us_hist_q;
    us_cons_d  = us_cons_q;
    us_op_d    = us_op_q;
    us_first_d = us_first_q;
    enq_d      = 1'b0;
    enqf_d     = 1'b0;
    us_ev      = 1'b0;
    us_err     = 1'b0;
    if (tk.sec_tick) us_tmr_d = 5'(us_tmr_q + 5'h01); // [RL19]
    unique case (us_st_q)
      US_OFF:  if (en) enq_d = 1'b1;
      US_WAIT: begin
        if (rx_rep_valid) begin
          us_ev  = 1'b1;
          us_err = !rx_rep_seq_ok; // [RL18]
          us_st_d = US_IDLE;
        end else if (us_exp) begin
          us_ev  = 1'b1;
          us_err = 1'b1;           // [RL18]
          enq_d  = 1'b1;
        end
      end
      US_IDLE: if (us_exp) enq_d = 1'b1; // [RL9]
      default: us_st_d = US_OFF;
    endcase
    if (enq_d) begin
      us_st_d  = US_WAIT;
      us_tmr_d = 5'h00;
      us_seq_d = seq_inc(us_seq_q); // [RL2]
      if (8'(us_poll_q + 8'h01) >= fpc_q) begin // [RL10]
        enqf_d    = 1'b1;
        us_poll_d = 8'h00;
      end else begin
        us_poll_d = 8'(us_poll_q + 8'h01);
      end
    end
    if (us_ev) begin
      us_hist_d  = {us_hist_q[HIST_W-2:0], us_err};
      us_cons_d  = cons_inc(us_cons_q, us_err);
      us_op_d    = op_next(us_op_q, us_first_q, ctrl_q[CTRL_FAST],
                           us_hist_d, us_cons_d, eth_q, mwc_q);
      us_first_d = 1'b0;
    end
    if (!en) begin // [RL16]
      us_st_d    = US_OFF;
      us_tmr_d   = 5'h00;
      us_poll_d  = 8'h00;
      us_hist_d  = '0;
      us_cons_d  = 4'h0;
      us_op_d    = 1'b0;
      us_first_d = 1'b1;
      enq_d      = 1'b0;
      enqf_d     = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Network side: enquiry supervision and replies
  // ----------------------------------------------------------------
  always_comb begin
    nw_tmr_d   = nw_tmr_q;
    nw_seq_d   = nw_seq_q;
    nw_hist_d  = nw_hist_q;
    nw_cons_d  = nw_cons_q;
    nw_op_d    = nw_op_q;
    nw_first_d = nw_first_q;
    rep_d      = 1'b0;
    repf_d     = 1'b0;
    chg_d      = chg_q;
    nw_ev      = 1'b0;
    nw_err     = 1'b0;
    if (tk.sec_tick) nw_tmr_d = 5'(nw_tmr_q + 5'h01);
    if (en && rx_enq_valid) begin // [RL1]
      nw_ev    = 1'b1;
      nw_err   = !rx_enq_seq_ok;  // [RL18]
      nw_tmr_d = 5'h00;
      rep_d    = 1'b1;
      repf_d   = rx_enq_full_req || chg_q; // [RL14]
      nw_seq_d = seq_inc(nw_seq_q);
      if (repf_d) chg_d = 1'b0;
    end else if (en && nw_exp) begin // [RL6]
      nw_ev    = 1'b1;
      nw_err   = 1'b1;                // [RL18]
      nw_tmr_d = 5'h00;
    end
    if (pvc_change) chg_d = 1'b1;     // [RL14]
    if (nw_ev) begin
      nw_hist_d  = {nw_hist_q[HIST_W-2:0], nw_err};
      nw_cons_d  = cons_inc(nw_cons_q, nw_err);
      nw_op_d    = op_next(nw_op_q, nw_first_q, ctrl_q[CTRL_FAST],
                           nw_hist_d, nw_cons_d, eth_q, mwc_q);
      nw_first_d = 1'b0;
    end
    if (!en) begin
      nw_tmr_d   = 5'h00;
      nw_hist_d  = '0;
      nw_cons_d  = 4'h0;
      nw_op_d    = 1'b0;
      nw_first_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // PVC status in both directions
  // ----------------------------------------------------------------
  always_comb begin
    // Sent bit is built from local facts only, never from rx_pvc_active.
    act_d  = pvc_dest_ok && pvc_path_ok && us_op_q && nw_op_q; // [RL13] [RL15]
    up_d   = us_op_q && nw_op_q;
    fwd_d  = en && rx_pvc_valid &&
             (rx_pvc_full || ctrl_q[CTRL_FWDA]);               // [RL12]
    fidx_d = fwd_d ? rx_pvc_idx : fidx_q;
    fact_d = fwd_d ? rx_pvc_active : fact_q;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin // [RL19]
      ctrl_q <= CTRL_RST;   fpc_q <= FPC_DEF;   // [RL3]
      eth_q <= ETH_DEF;     mwc_q <= MWC_DEF;   // [RL4]
      pit_q <= PIT_DEF;     pvt_q <= PVT_DEF;   // [RL5] [RL6]
      rdata_q <= 32'h0000_0000;
      chg_q <= 1'b0;        us_st_q <= US_OFF;
      us_tmr_q <= 5'h00;    nw_tmr_q <= 5'h00;
      us_poll_q <= 8'h00;   us_seq_q <= 8'h00;   nw_seq_q <= 8'h00;
      us_hist_q <= '0;      nw_hist_q <= '0;
      us_cons_q <= 4'h0;    nw_cons_q <= 4'h0;
      us_op_q <= 1'b0;      nw_op_q <= 1'b0;     // [RL16]
      us_first_q <= 1'b1;   nw_first_q <= 1'b1;
      enq_q <= 1'b0;  enqf_q <= 1'b0;  rep_q <= 1'b0;  repf_q <= 1'b0;
      act_q <= 1'b0;  fwd_q <= 1'b0;   fact_q <= 1'b0; up_q <= 1'b0;
      fidx_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;     fpc_q <= fpc_d;
      eth_q <= eth_d;       mwc_q <= mwc_d;
      pit_q <= pit_d;       pvt_q <= pvt_d;
      rdata_q <= rdata_d;
      chg_q <= chg_d;       us_st_q <= us_st_d;
      us_tmr_q <= us_tmr_d; nw_tmr_q <= nw_tmr_d;
      us_poll_q <= us_poll_d; us_seq_q <= us_seq_d; nw_seq_q <= nw_seq_d;
      us_hist_q <= us_hist_d; nw_hist_q <= nw_hist_d;
      us_cons_q <= us_cons_d; nw_cons_q <= nw_cons_d;
      us_op_q <= us_op_d;     nw_op_q <= nw_op_d;
      us_first_q <= us_first_d; nw_first_q <= nw_first_d;
      enq_q <= enq_d;  enqf_q <= enqf_d;  rep_q <= rep_d;  repf_q <= repf_d;
      act_q <= act_d;  fwd_q <= fwd_d;    fact_q <= fact_d; up_q <= up_d;
      fidx_q <= fidx_d;
    end
  end

  assign reg_rdata      = rdata_q;
  assign tx_enq         = enq_q;
  assign tx_enq_full    = enqf_q;
  assign tx_enq_seq     = us_seq_q;
  assign tx_rep         = rep_q;
  assign tx_rep_full    = repf_q;
  assign tx_rep_seq     = nw_seq_q;
  assign tx_pvc_active  = act_q; // [RL17]
  assign uni_pvc_valid  = fwd_q;
  assign uni_pvc_idx    = fidx_q;
  assign uni_pvc_active = fact_q;
  assign link_up        = up_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_ENQ_ON_EXPIRY: assert property ( // [RL9]
    en && $past(en) && us_st_q == US_IDLE && us_exp |=> tx_enq)
    else $error("no enquiry after poll interval expiry");
  AST_FULL_CADENCE: assert property ( // [RL10]
    tx_enq |-> (tx_enq_full == (us_poll_q == 8'h00)))
    else $error("full report request out of cadence");
  AST_REPLY_TO_ENQ: assert property ( // [RL1]
    en && rx_enq_valid |=> tx_rep ##1 !tx_rep)
    else $error("peer enquiry not answered once");
  AST_FULL_AFTER_CHG: assert property ( // [RL14]
    en && chg_q && rx_enq_valid && !pvc_change |=> tx_rep_full && !chg_q)
    else $error("reply after change was not full");
  AST_INACTIVE: assert property ( // [RL4]
    err_count(us_hist_q, mwc_q) >= eth_q |-> !us_op_q ##1 !link_up)
    else $error("user side active above error threshold");
  AST_NW_TIMEOUT: assert property ( // [RL18]
    en && !rx_enq_valid && nw_exp |=> nw_hist_q[0] && nw_tmr_q == 5'h00)
    else $error("poll verify expiry not counted as error");
  AST_FORWARD: assert property ( // [RL12]
    en && rx_pvc_valid && rx_pvc_full |=>
      uni_pvc_valid && uni_pvc_active == $past(rx_pvc_active) &&
      uni_pvc_idx == $past(rx_pvc_idx))
    else $error("full report status not forwarded");
  AST_SENT_ACTIVE: assert property ( // [RL15]
    tx_pvc_active |-> $past(pvc_path_ok) && $past(pvc_dest_ok) && link_up)
    else $error("active sent without full path");
  AST_RANGES: assert property ( // [RL3]
    fpc_q >= FPC_MIN && pit_q >= TSEC_MIN && pit_q <= TSEC_MAX &&
    mwc_q >= NWIN_MIN && mwc_q <= NWIN_MAX)
    else $error("parameter outside legal range");
  AST_RESET_CLEAR: assert property ( // [RL19]
    $past(srst) |-> us_seq_q == 8'h00 && nw_seq_q == 8'h00 &&
      !us_op_q && us_poll_q == 8'h00)
    else $error("counters not cleared by reset");

  COV_FULL_ENQ: cover property (tx_enq && tx_enq_full);
  COV_US_UP:    cover property ($rose(us_op_q));
  COV_NW_DOWN:  cover property ($fell(nw_op_q));
  COV_REP_FULL: cover property (tx_rep && tx_rep_full);
endmodule
`default_nettype wire

// [core/nlp_tick_gen.sv]
// One-second tick divider for the poller timers.
`default_nettype none
module nlp_tick_gen
  import nlp_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic  core_clk, // System clock.
  input  wire logic  srst,     // Synchronous reset, active high.
  input  wire logic  run,      // Divider runs while high.
  nlp_tick_if.gen    tk        // Tick pulse out.
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          tick_q, tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d  = '0;
      tick_d = 1'b1; // [RL19]
    end else begin
      cnt_d = CW'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.sec_tick = tick_q;

  AST_TICK_SINGLE: assert property (@(posedge core_clk) disable iff (srst)
    (CYCLES > 1) && tick_q |=> !tick_q) // [RL19]
    else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// [core/nlp_tick_if.sv]
// Carrier of the one-second tick between divider and poller.
`default_nettype none
interface nlp_tick_if;
  logic sec_tick;
  modport gen (output sec_tick);
  modport snk (input sec_tick);
endinterface
`default_nettype wire

// [tb/nlp_peer.sv]
// Model of the peer network's polling engine facing the poller.
`default_nettype none
module nlp_peer #(
  parameter int GAP = 200
) (
  input  wire logic core_clk,       // System clock.
  input  wire logic srst,           // Sync reset, high.
  input  wire logic tx_enq,         // Enquiry from the poller.
  input  wire logic mute,           // Peer falls silent.
  input  wire logic ask_full,       // Enquiries ask full.
  output logic      rx_rep_valid,   // Reply pulse.
  output logic      rx_rep_seq_ok,  // Reply sequence ok.
  output logic      rx_enq_valid,   // Enquiry pulse.
  output logic      rx_enq_seq_ok,  // Enquiry sequence ok.
  output logic      rx_enq_full_req // Enquiry asks full.
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt;
  logic fire;
  initial begin
    {rx_rep_valid, rx_rep_seq_ok, rx_enq_valid} = '0;
    {rx_enq_seq_ok, rx_enq_full_req} = '0;
  end
  // Qualifiers toggle outside their pulse so stale values never pass.
  assign fire = (cnt == GAP - 1) && !mute;
  always @(posedge core_clk) begin
    cnt <= (srst || cnt == GAP - 1) ? 0 : cnt + 1;
    rx_rep_valid <= tx_enq && !mute && !srst;
    rx_rep_seq_ok <= tx_enq ? 1'b1 : !rx_rep_seq_ok;
    rx_enq_valid <= fire && !srst;
    rx_enq_seq_ok <= fire ? 1'b1 : !rx_enq_seq_ok;
    rx_enq_full_req <= fire ? ask_full : !rx_enq_full_req;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the link integrity poller.
`default_nettype none
module tb;
  import nlp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, srst = 1, reg_we = 0, reg_re = 0, mute = 0;
  logic [7:0] reg_addr = '0, tx_enq_seq, tx_rep_seq;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic rx_rep_valid, rx_rep_seq_ok, rx_enq_valid, rx_enq_seq_ok;
  logic rx_enq_full_req, rx_pvc_valid = 0, rx_pvc_full = 0, ask_full = 0;
  logic [9:0] rx_pvc_idx = '0, uni_pvc_idx;
  logic rx_pvc_active = 0, pvc_change = 0, pvc_dest_ok = 0, pvc_path_ok = 0;
  logic tx_enq, tx_enq_full, tx_rep, tx_rep_full, tx_pvc_active, link_up;
  logic uni_pvc_valid, uni_pvc_active, last_full;
  int n_fail, checks, n_enq, n_rep, n0;
  nlp_poller #(.TICK_LEN(20), .PVC_W(10)) uut (.core_clk, .srst, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata, .rx_rep_valid, .rx_rep_seq_ok,
    .rx_enq_valid, .rx_enq_seq_ok, .rx_enq_full_req, .rx_pvc_valid,
    .rx_pvc_full, .rx_pvc_idx, .rx_pvc_active, .pvc_change, .pvc_dest_ok,
    .pvc_path_ok, .tx_enq, .tx_enq_full, .tx_enq_seq, .tx_rep, .tx_rep_full,
    .tx_rep_seq, .tx_pvc_active, .uni_pvc_valid, .uni_pvc_idx,
    .uni_pvc_active, .link_up);
  nlp_peer #(.GAP(200)) peer (.core_clk, .srst, .tx_enq, .mute, .ask_full,
    .rx_rep_valid, .rx_rep_seq_ok, .rx_enq_valid, .rx_enq_seq_ok,
    .rx_enq_full_req);
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_we <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_we <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_re <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  endtask
  // Sends one PVC element and checks what is passed on toward the UNI.
  task automatic pvc(input logic f, input logic [9:0] i, input logic a,
                     input logic fwd);
    @(posedge core_clk);
    rx_pvc_valid <= 1;
    rx_pvc_full <= f;
    rx_pvc_idx <= i;
    rx_pvc_active <= a;
    @(posedge core_clk);
    {rx_pvc_valid, rx_pvc_idx, rx_pvc_active} <= {1'b0, ~i, ~a};
    @(negedge core_clk);
    chk({uni_pvc_valid, uni_pvc_idx & {10{fwd}}, uni_pvc_active & fwd,
         tx_pvc_active}, {fwd, i & {10{fwd}}, a & fwd, 1'b1});
  endtask
  task automatic wait_rep(input logic exp);
    int n;
    n = n_rep;
    repeat (400) if (n_rep == n) @(negedge core_clk);
    chk({n_rep != n, last_full}, {1'b1, exp});
  endtask
  task automatic wait_link(input logic exp);
    repeat (2000) if (link_up !== exp) @(negedge core_clk);
  endtask
  always @(posedge core_clk) begin
    if (tx_enq) begin
      n_enq++;
      chk({tx_enq_full, tx_enq_seq}, {n_enq % 2 == 0, 8'(n_enq)});
    end
    if (tx_rep) begin
      n_rep++;
      last_full = tx_rep_full;
      chk(tx_rep_seq, 32'(8'(n_rep)));
    end
  end
  initial begin
    repeat (8000) @(posedge core_clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 0;
    rdc(REG_CTRL, 0);
    rdc(REG_FPC, 6);
    rdc(REG_WIN, 32'h0000_0403);
    rdc(REG_TMR, 32'h0000_0F0A);
    rdc(REG_SEQ, 0);
    rdc(8'h3C, 0);
    wr(REG_FPC, 0);
    rdc(REG_FPC, 6);
    wr(REG_WIN, 32'h0000_0B03);
    rdc(REG_WIN, 32'h0000_0403);
    wr(REG_TMR, 32'h0000_1F04);
    rdc(REG_TMR, 32'h0000_0F0A);
    wr(REG_FPC, 32'h0000_00FF);
    rdc(REG_FPC, 32'h0000_00FF);
    wr(REG_WIN, 32'h0000_0405);
    rdc(REG_STAT, 32'h0000_0020);
    wr(REG_WIN, 32'h0000_0403);
    wr(REG_TMR, 32'h0000_0A0A);
    rdc(REG_STAT, 32'h0000_0040);
    wr(REG_TMR, 32'h0000_0F0A);
    wr(REG_FPC, 2);
    pvc_dest_ok <= 1;
    pvc_path_ok <= 1;
    wr(REG_CTRL, 1);
    repeat (600) if (n_enq < 2) @(negedge core_clk);
    chk({link_up, 8'(n_enq)}, {1'b0, 8'd2});
    wait_link(1);
    chk({link_up, n_enq >= 4}, 2'b11);
    rdc(REG_STAT, 32'h0000_0007);
    pvc(1, 10'h155, 0, 1);
    pvc(1, 10'h2AA, 1, 1);
    pvc(0, 10'h0F0, 1, 0);
    wr(REG_CTRL, 5);
    pvc(0, 10'h30F, 0, 1);
    @(posedge core_clk);
    ask_full <= 1;
    wait_rep(1);
    @(posedge core_clk);
    ask_full <= 0;
    wait_rep(0);
    @(posedge core_clk);
    pvc_change <= 1;
    @(posedge core_clk);
    pvc_change <= 0;
    wait_rep(1);
    wait_rep(0);
    @(posedge core_clk);
    pvc_path_ok <= 0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(tx_pvc_active, 0);
    @(posedge core_clk);
    mute <= 1;
    n0 = n_enq;
    wait_link(0);
    chk({link_up, n_enq - n0 >= 3}, 2'b01);
    report_and_stop;
  end
endmodule
`default_nettype wire
